// [eeprom_pkg.sv]
package eeprom_pkg;
	localparam int CLK_PERIOD_NS = 40;
	// plain default; the real program time depends on the part
	localparam int PROGRAM_CYCLE_TIME_US = 5;
	localparam int PROG_CYCLES_DEF = (PROGRAM_CYCLE_TIME_US * 1000)
		/ CLK_PERIOD_NS;
	localparam int DENSITY_DEF = 16384;
	localparam logic [3:0] DEV_TYPE = 4'ha;
	localparam int PAGE_BYTES = 64;
	localparam int PAGE_W = 6;
	localparam logic [6:0] PAGE_FULL = 7'h40;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] STOP_SLOT = 4'h1;
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_PWR = 2;
	localparam int SY_WP = 3;
	localparam int SY_STRAP = 4;
	localparam int SY_W = 7;
	// scl and sda bits start at the idle bus level, the rest low
	localparam logic [SY_W-1:0] SY_RST = 7'h03;
	typedef enum logic [6:0] {
		PH_IDLE = 7'h01,
		PH_DEVSEL = 7'h02,
		PH_ADDR_HI = 7'h04,
		PH_ADDR_LO = 7'h08,
		PH_WDATA = 7'h10,
		PH_RDATA = 7'h20,
		PH_PROG = 7'h40
	} state_e;
endpackage : eeprom_pkg

// [bus_evt_if.sv]
`timescale 1ns/1ps
interface bus_evt_if;
	logic start_p;
	logic stop_p;
	logic scl_rise_p;
	logic scl_fall_p;
	logic sda_s;
	logic pwr_ok;
	logic wp_s;
	logic [2:0] strap_s;
	modport det(output start_p, stop_p, scl_rise_p, scl_fall_p, sda_s,
		pwr_ok, wp_s, strap_s);
	modport core(input start_p, stop_p, scl_rise_p, scl_fall_p, sda_s,
		pwr_ok, wp_s, strap_s);
endinterface : bus_evt_if

// [bus_cond_detect.sv]
`timescale 1ns/1ps
module bus_cond_detect
	import eeprom_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic power_good,
	input wire logic write_protect_in,
	input wire logic [2:0] strap_in,
	bus_evt_if.det ev
);
	logic [SY_W-1:0] s1_ff;
	logic [SY_W-1:0] s2_ff;
	logic scl_d_ff;
	logic sda_d_ff;
	wire [SY_W-1:0] raw = {strap_in, write_protect_in, power_good,
		sda_in, scl_in};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// idle-level reset keeps a false scl edge away after reset
			s1_ff <= SY_RST;
			s2_ff <= SY_RST;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			scl_d_ff <= s2_ff[SY_SCL];
			sda_d_ff <= s2_ff[SY_SDA];
		end
	end

	// floating straps and protect pin rely on pad pull-downs: read as 0
	assign ev.strap_s = s2_ff[SY_STRAP +: 3]; // R5
	assign ev.wp_s = s2_ff[SY_WP]; // R11
	assign ev.pwr_ok = s2_ff[SY_PWR];
	assign ev.sda_s = s2_ff[SY_SDA];
	// sda moving while scl stays high marks start and stop
	assign ev.start_p = scl_d_ff && s2_ff[SY_SCL] && sda_d_ff
		&& !s2_ff[SY_SDA];
	assign ev.stop_p = scl_d_ff && s2_ff[SY_SCL] && !sda_d_ff
		&& s2_ff[SY_SDA];
	assign ev.scl_rise_p = !scl_d_ff && s2_ff[SY_SCL]; // R18
	assign ev.scl_fall_p = scl_d_ff && !s2_ff[SY_SCL]; // R18
endmodule : bus_cond_detect

// [i2c_eeprom_slave.sv]
`timescale 1ns/1ps
// How it works
// R1 - array of 4096, 8192 or 16384 bytes set by a build parameter
// R2 - answer only select bytes whose top nibble is 1010
// R3 - select byte arrives most significant bit first
// R4 - select bits b3..b1 must equal the three strap inputs
// R5 - unconnected straps count as zero
// R6 - master opens every transfer with start, select byte, acknowledge
// R7 - device acknowledges each written byte in the ninth bit time; the code no-acks data bytes after the 64th of a write
// R8 - master acknowledges each read byte in the ninth bit time
// R9 - writes end with stop after ack, reads with stop after no-ack
// R10 - protect input high blocks any array change; code only refuses data bytes, so bytes staged before it rose still program
// R11 - unconnected protect input counts as low
// R12 - protect high: ack select and address, no-ack every data byte
// R13 - below power threshold, ignore the bus and never acknowledge
// R14 - passing power threshold resets state into standby idle
// R15 - supply falling below threshold stops all responses at once
// R16 - master keeps device idle with no program cycle before power-down
// R17 - data line is only pulled low or released
// R18 - all transfers are timed by the master serial clock
// R19 - select bit b0 is one for read, zero for write
// R20 - sixteen-bit address sent high byte then low byte
// R21 - stop right after a data ack slot starts programming, else not
// R22 - during programming the data line is released and bus ignored
// R23 - program cycle lasts a configurable count then back to standby
module i2c_eeprom_slave
	import eeprom_pkg::*;
#(
	parameter int DENSITY = DENSITY_DEF, // R1
	parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic strap_sel_bit0,
	input wire logic strap_sel_bit1,
	input wire logic strap_sel_bit2,
	input wire logic write_protect_in,
	input wire logic power_good
);
	localparam int ADDR_W = $clog2(DENSITY);

	bus_evt_if ev();

	bus_cond_detect u_det (
		.clk(clk),
		.reset_n(reset_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.power_good(power_good),
		.write_protect_in(write_protect_in),
		.strap_in({strap_sel_bit2, strap_sel_bit1, strap_sel_bit0}),
		.ev(ev)
	);

	state_e state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] shift_ff, nxt_shift;
	logic in_ack_ff, nxt_in_ack;
	logic drive_ff, nxt_drive;
	logic rw_ff, nxt_rw;
	logic [15:0] addr_ff, nxt_addr;
	logic [6:0] pg_cnt_ff, nxt_pg_cnt;
	logic [31:0] prog_cnt_ff, nxt_prog_cnt;
	logic [7:0] mem [DENSITY]; // R1
	logic [7:0] pg_buf [PAGE_BYTES];

	wire act_w = ev.pwr_ok && !ev.start_p && !ev.stop_p
		&& state_ff != PH_IDLE && state_ff != PH_PROG;
	wire rise_w = act_w && ev.scl_rise_p;
	wire fall_w = act_w && ev.scl_fall_p;
	wire byte_end_w = fall_w && cnt_ff == BIT_LAST && !in_ack_ff;
	wire ack_end_w = fall_w && in_ack_ff;
	wire type_ok_w = shift_ff[7:4] == DEV_TYPE; // R2
	wire strap_ok_w = shift_ff[3:1] == ev.strap_s; // R4
	wire data_ok_w = !ev.wp_s && pg_cnt_ff != PAGE_FULL; // R10 R12
	wire buf_we_w = byte_end_w && state_ff == PH_WDATA && data_ok_w;
	// stop one scl high after the data ack: the 10th bit slot
	wire prog_go_w = ev.pwr_ok && ev.stop_p && state_ff == PH_WDATA
		&& !in_ack_ff && cnt_ff == STOP_SLOT && pg_cnt_ff != 7'h00; // R21
	wire prog_done_w = prog_cnt_ff == 32'(PROG_CYCLES - 1); // R23
	wire prog_we_w = state_ff == PH_PROG
		&& prog_cnt_ff < 32'(pg_cnt_ff);
	// row bits stay put; only the in-page offset wraps
	wire [ADDR_W-1:0] prog_addr_w = {addr_ff[ADDR_W-1:PAGE_W],
		addr_ff[PAGE_W-1:0] + prog_cnt_ff[PAGE_W-1:0]};
	wire [7:0] rd_byte_w = mem[addr_ff[ADDR_W-1:0]];

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_in_ack = in_ack_ff;
		nxt_drive = drive_ff;
		nxt_rw = rw_ff;
		nxt_addr = addr_ff;
		nxt_pg_cnt = pg_cnt_ff;
		nxt_prog_cnt = prog_cnt_ff;
		if (!ev.pwr_ok) begin
			// held in standby until the supply is good again
			nxt_state = PH_IDLE; // R13 R14 R15
			nxt_cnt = 4'h0;
			nxt_in_ack = 1'b0;
			nxt_drive = 1'b0;
			nxt_pg_cnt = 7'h00;
		end else if (state_ff == PH_PROG) begin
			nxt_prog_cnt = prog_cnt_ff + 32'h1; // R22
			if (prog_done_w) begin
				nxt_state = PH_IDLE; // R23
				nxt_addr = addr_ff + {9'h000, pg_cnt_ff};
				nxt_pg_cnt = 7'h00;
			end
		end else if (ev.start_p) begin
			nxt_state = PH_DEVSEL;
			nxt_cnt = 4'h0;
			nxt_in_ack = 1'b0;
			nxt_drive = 1'b0;
			nxt_pg_cnt = 7'h00;
		end else if (ev.stop_p) begin
			nxt_cnt = 4'h0;
			nxt_in_ack = 1'b0;
			nxt_drive = 1'b0;
			if (prog_go_w) begin
				nxt_state = PH_PROG; // R21
				nxt_prog_cnt = 32'h0;
			end else begin
				nxt_state = PH_IDLE; // R9
				nxt_pg_cnt = 7'h00;
			end
		end else if (rise_w) begin
			if (in_ack_ff) begin
				if (state_ff == PH_RDATA && ev.sda_s)
					nxt_state = PH_IDLE; // R9
			end else begin
				nxt_cnt = cnt_ff + 4'h1;
				if (state_ff != PH_RDATA)
					nxt_shift = {shift_ff[6:0], ev.sda_s}; // R3
			end
		end else if (byte_end_w) begin
			nxt_in_ack = 1'b1;
			case (state_ff)
				PH_DEVSEL: begin
					nxt_drive = type_ok_w && strap_ok_w; // R2 R4 R7
					nxt_rw = shift_ff[0]; // R19
					if (!(type_ok_w && strap_ok_w))
						nxt_state = PH_IDLE;
				end
				PH_ADDR_HI: begin
					nxt_drive = 1'b1; // R7 R12
					nxt_addr = {shift_ff, addr_ff[7:0]}; // R20
				end
				PH_ADDR_LO: begin
					nxt_drive = 1'b1; // R7 R12
					nxt_addr = {addr_ff[15:8], shift_ff}; // R20
				end
				PH_WDATA: begin
					nxt_drive = data_ok_w; // R7 R12
					if (data_ok_w)
						nxt_pg_cnt = pg_cnt_ff + 7'h01;
				end
				default: nxt_drive = 1'b0; // R8
			endcase
		end else if (ack_end_w) begin
			nxt_in_ack = 1'b0;
			nxt_cnt = 4'h0;
			nxt_drive = 1'b0;
			case (state_ff)
				PH_DEVSEL: nxt_state = rw_ff ? PH_RDATA : PH_ADDR_HI;
				PH_ADDR_HI: nxt_state = PH_ADDR_LO;
				PH_ADDR_LO: nxt_state = PH_WDATA;
				default: nxt_state = state_ff;
			endcase
			if (state_ff == PH_RDATA || (state_ff == PH_DEVSEL && rw_ff))
			begin
				nxt_shift = rd_byte_w;
				nxt_drive = !rd_byte_w[7]; // R3 R17
				nxt_addr = addr_ff + 16'h0001;
			end
		end else if (fall_w && state_ff == PH_RDATA) begin
			nxt_shift = {shift_ff[6:0], 1'b0};
			nxt_drive = !shift_ff[6]; // R17
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= PH_IDLE; // R14
			cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			in_ack_ff <= 1'b0;
			drive_ff <= 1'b0;
			rw_ff <= 1'b0;
			addr_ff <= 16'h0000;
			pg_cnt_ff <= 7'h00;
			prog_cnt_ff <= 32'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			in_ack_ff <= nxt_in_ack;
			drive_ff <= nxt_drive;
			rw_ff <= nxt_rw;
			addr_ff <= nxt_addr;
			pg_cnt_ff <= nxt_pg_cnt;
			prog_cnt_ff <= nxt_prog_cnt;
		end
	end

	// staged bytes reach the array only inside the program cycle, so a
	// transfer cut short by a stop in the wrong slot changes nothing
	always_ff @(posedge clk) begin
		if (buf_we_w)
			pg_buf[pg_cnt_ff[PAGE_W-1:0]] <= shift_ff; // R10
		if (prog_we_w)
			mem[prog_addr_w] <= pg_buf[prog_cnt_ff[PAGE_W-1:0]]; // R21
	end

	assign sda_out = 1'b0; // R17
	assign sda_oe = drive_ff && ev.pwr_ok; // R15

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_byte_end;
		byte_end_w;
	endsequence
	sequence s_slot_stop;
		ev.pwr_ok && ev.stop_p && state_ff == PH_WDATA && !in_ack_ff
			&& cnt_ff == STOP_SLOT && pg_cnt_ff != 7'h00;
	endsequence

	AST_DRIVE_ACTIVE: assert property ( // R17
		sda_oe |-> state_ff != PH_IDLE && state_ff != PH_PROG)
		else $error("data line driven outside a transfer");
	AST_PROG_QUIET: assert property ( // R22
		state_ff == PH_PROG |-> !sda_oe ##1 (!sda_oe || !ev.pwr_ok
			|| state_ff != PH_PROG))
		else $error("data line driven during program cycle");
	AST_POWER_QUIET: assert property ( // R13
		!ev.pwr_ok |-> !sda_oe ##1 state_ff == PH_IDLE)
		else $error("response while power is below threshold");
	AST_TYPE_MISMATCH: assert property ( // R2
		s_byte_end ##0 (state_ff == PH_DEVSEL && !type_ok_w)
			|=> state_ff == PH_IDLE && !sda_oe)
		else $error("wrong type nibble was answered");
	AST_STRAP_MISMATCH: assert property ( // R4
		s_byte_end ##0 (state_ff == PH_DEVSEL && !strap_ok_w)
			|=> state_ff == PH_IDLE && !sda_oe)
		else $error("select bits differing from straps were answered");
	// the ack must come at once and still stand one clk later
	AST_ADDR_ACK: assert property ( // R7
		s_byte_end ##0 (state_ff == PH_ADDR_HI || state_ff == PH_ADDR_LO)
			|=> (sda_oe && in_ack_ff || !ev.pwr_ok)
			##1 (sda_oe || !in_ack_ff || !ev.pwr_ok))
		else $error("address byte not acknowledged");
	AST_DATA_NACK: assert property ( // R12
		s_byte_end ##0 (state_ff == PH_WDATA && ev.wp_s)
			|=> !sda_oe && $stable(pg_cnt_ff))
		else $error("protected data byte acknowledged");
	AST_PROG_START: assert property ( // R21
		s_slot_stop |=> state_ff == PH_PROG && prog_cnt_ff == 32'h0)
		else $error("stop in data slot did not start programming");
	AST_PROG_END: assert property ( // R23
		state_ff == PH_PROG && prog_done_w && ev.pwr_ok
			|=> state_ff == PH_IDLE && pg_cnt_ff == 7'h00)
		else $error("program cycle did not end on its count");
	AST_READ_NACK: assert property ( // R9
		rise_w && in_ack_ff && state_ff == PH_RDATA && ev.sda_s
			|=> state_ff == PH_IDLE ##1 !sda_oe)
		else $error("read continued after master no-ack");
endmodule : i2c_eeprom_slave

// [i2c_master_model.sv]
`timescale 1ns/1ps
module i2c_master_model (
	input wire logic clk,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low
);
	// scl idles high between frames; sda is only pulled low or released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	task automatic start_cond();
		sda_low <= 1'b0;
		hold(4);
		scl <= 1'b1;
		hold(4);
		sda_low <= 1'b1;
		hold(4);
		scl <= 1'b0;
		hold(4);
	endtask : start_cond
	task automatic stop_cond();
		sda_low <= 1'b1;
		hold(4);
		scl <= 1'b1;
		hold(4);
		sda_low <= 1'b0;
		hold(4);
	endtask : stop_cond
	// sda moves one clk after scl falls, never while scl is high
	task automatic send_bit(input logic b, output logic seen);
		// three clk here, four with scl high and one after the fall: 320 ns per bit
		sda_low <= !b;
		hold(3);
		scl <= 1'b1;
		hold(4);
		seen = sda_wire;
		scl <= 1'b0;
		hold(1);
	endtask : send_bit
	task automatic send_byte(input logic [7:0] d, output logic ack_n);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			send_bit(d[i], s);
		end
		send_bit(1'b1, ack_n);
	endtask : send_byte
	task automatic recv_byte(input logic ack_n, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			send_bit(1'b1, d[i]);
		end
		send_bit(ack_n, s);
	endtask : recv_byte
endmodule : i2c_master_model

// [i2c_eeprom_slave_front_end_test.sv]
`timescale 1ns/1ps
module i2c_eeprom_slave_front_end_test;
	import eeprom_pkg::*;
	localparam int DENS = 4096;
	localparam int PROG = 400;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic pg = 1'b0;
	logic wp = 1'b0;
	logic [2:0] strap = 3'h0;
	logic sda_out, sda_oe, scl, sda_low;
	// pulled up unless the master or the device's enabled driver holds it
	wire sda_w = !sda_low && (sda_oe ? sda_out : 1'b1);
	int err_total = 0;
	int n_compared = 0;
	logic [31:0] rng = 32'h00007f5f;
	logic [7:0] mem [int];
	always #20 clk = ~clk;
	i2c_eeprom_slave #(.DENSITY(DENS), .PROG_CYCLES(PROG)) i2c_eeprom_slave_i (
		.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .strap_sel_bit0(strap[0]),
		.strap_sel_bit1(strap[1]), .strap_sel_bit2(strap[2]),
		.write_protect_in(wp), .power_good(pg));
	i2c_master_model i2c_master_model_i (.clk(clk), .sda_wire(sda_w),
		.scl(scl), .sda_low(sda_low));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic check_ack(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t ack got %b exp %b", $time, got, exp);
		end
	endtask : check_ack
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t data got %h exp %h", $time, got, exp);
		end
	endtask : check_byte
	always @(posedge clk) if (sda_oe === 1'b1) check_ack(sda_out, 1'b0);
	task automatic sel(input logic [3:0] t, input logic [2:0] cs,
			input logic r, input logic exp_n);
		logic a;
		i2c_master_model_i.start_cond();
		i2c_master_model_i.send_byte({t, cs, r}, a);
		check_ack(a, exp_n);
	endtask : sel
	task automatic addr(input int ad);
		logic a;
		sel(DEV_TYPE, strap, 1'b0, 1'b0);
		i2c_master_model_i.send_byte(8'(ad >> 8), a);
		check_ack(a, 1'b0);
		i2c_master_model_i.send_byte(8'(ad), a);
		check_ack(a, 1'b0);
	endtask : addr
	// abort cuts the next byte short with a stop, so nothing may program
	task automatic wr(input int ad, input int n, input logic abort);
		logic a;
		logic [7:0] q [$];
		addr(ad);
		for (int i = 0; i < n; i++) begin
			rng = xs(rng);
			i2c_master_model_i.send_byte(rng[7:0], a);
			check_ack(a, wp);
			q.push_back(rng[7:0]);
		end
		for (int i = 0; abort && i < 3; i++) begin
			i2c_master_model_i.send_bit(1'b1, a);
		end
		i2c_master_model_i.stop_cond();
		if (!abort && !wp) begin
			foreach (q[i]) mem[ad + i] = q[i];
			sel(DEV_TYPE, strap, 1'b0, 1'b1);
			i2c_master_model_i.stop_cond();
			i2c_master_model_i.hold(PROG);
		end
	endtask : wr
	task automatic rd(input int ad, input int n);
		logic [7:0] d;
		addr(ad);
		sel(DEV_TYPE, strap, 1'b1, 1'b0);
		for (int i = 0; i < n; i++) begin
			i2c_master_model_i.recv_byte(i == n - 1, d);
			check_byte(d, mem[ad + i]);
		end
		i2c_master_model_i.stop_cond();
	endtask : rd
	initial begin
		// traffic takes about 7200 clk; allow well over twice that
		#(CLK_PERIOD_NS * 20000);
		err_total++;
		complete_run();
	end
	initial begin
		int a;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		i2c_master_model_i.hold(4);
		sel(DEV_TYPE, strap, 1'b0, 1'b1);
		i2c_master_model_i.stop_cond();
		pg <= 1'b1;
		i2c_master_model_i.hold(4);
		wr(12'h002, 2, 1'b0);
		rd(12'h002, 2);
		rng = xs(rng);
		strap <= rng[2:0];
		a = {rng[11:6], 6'h04};
		i2c_master_model_i.hold(2);
		wr(a, 4, 1'b0);
		rd(a, 4);
		for (int t = 0; t < 16; t++) begin
			sel(4'(t), strap, 1'b0, 4'(t) != DEV_TYPE);
			i2c_master_model_i.stop_cond();
		end
		for (int k = 0; k < 3; k++) begin
			sel(DEV_TYPE, strap ^ 3'(1 << k), 1'b0, 1'b1);
			i2c_master_model_i.stop_cond();
		end
		wp <= 1'b1;
		wr(a, 2, 1'b0);
		wp <= 1'b0;
		wr(a + 1, 2, 1'b1);
		rd(a, 4);
		pg <= 1'b0;
		i2c_master_model_i.hold(3);
		sel(DEV_TYPE, strap, 1'b0, 1'b1);
		i2c_master_model_i.stop_cond();
		pg <= 1'b1;
		i2c_master_model_i.hold(4);
		rd(a, 4);
		complete_run();
	end
endmodule : i2c_eeprom_slave_front_end_test
